// file: design/fwg_pkg.sv
// shared constants and types for the flash write and lock guard
package fwg_pkg;
    localparam int ADDR_W = 16;
    localparam int PAGE_BITS = 9; // 512-byte pages
    localparam int PAGE_W = ADDR_W - PAGE_BITS;
    localparam logic [15:0] USER_TOP = 16'h3dff;
    localparam int FLASH_BYTES = 16'h3e00;
    localparam logic [15:0] LOCK_ADDR = 16'h3dff;
    localparam logic [7:0] KEY_FIRST = 8'ha5;
    localparam logic [7:0] KEY_SECOND = 8'hf1;
    localparam logic [7:0] ERASED = 8'hff;
    // control byte fields
    localparam int CTRL_WE_BIT = 0;
    localparam int CTRL_EE_BIT = 1;
    // apb map of the controller
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_INT_STAT = 8'h10;
    localparam logic [7:0] REG_INT_CLR = 8'h14;
    localparam logic [7:0] REG_INT_EN = 8'h18;
    localparam int CMD_SRC_BIT = 3;
    localparam int INT_DONE = 0;
    localparam int INT_REFUSED = 1;
    localparam int INT_FERR = 2;
    localparam logic [2:0] INT_RESET = 3'h0;

    typedef enum logic [2:0] {
        FWG_OP_NONE, FWG_OP_CTRL_WR, FWG_OP_KEY_WR, FWG_OP_XDATA_WR, FWG_OP_XDATA_RD,
        FWG_OP_CODE_RD
    } fwg_op_t;
endpackage

// file: design/fwg_if.sv
// link between the access controller and the flash guard
`timescale 1ns/1ns
interface fwg_if;
    logic req;
    fwg_pkg::fwg_op_t op;
    logic src_debug;
    logic [15:0] addr;
    logic [15:0] exec_addr;
    logic [7:0] wdata;
    logic resp;
    logic [7:0] rdata;
    logic refused;
    logic ferr_reset;

    modport guard (input req, op, src_debug, addr, exec_addr, wdata,
                   output resp, rdata, refused, ferr_reset);
    modport ctrl (output req, op, src_debug, addr, exec_addr, wdata,
                  input resp, rdata, refused, ferr_reset);
endinterface

// file: design/fwg_guard.sv
// flash guard: enables, unlock keys, page lock policy and the flash array
// Function
// - software erases the target page before writing
// - software sets write enable, clears erase enable
// - keys a5 then f1 precede each write
// - key pair repeated for every programmed byte
// - software clears write enable when finished
// - data writes to flash, data reads to ram
// - write needs write enable, erase needs both
// - lock page locked when lock byte not ff
// - unlocked pages open to every source
// - locked pages: debug refused, unlocked firmware errors
// - lock page guarded the same while locked
// - lock page erasable while nothing is locked
// - access above user space raises error reset; a debug access there is refused instead
// - error reset sets the flash error flag
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module fwg_guard
    import fwg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    fwg_if.guard lnk,
    input wire logic flag_clear,
    output logic flash_error_flag,
    output logic store_write_enable,
    output logic store_erase_enable,
    output logic ram_we,
    output logic ram_re,
    output logic [15:0] ram_addr,
    output logic [7:0] ram_wdata,
    input wire logic [7:0] ram_rdata
);
    import fwg_pkg::*;

    typedef enum logic [1:0] {FWG_LK_IDLE, FWG_LK_HALF, FWG_LK_OPEN} fwg_lk_t;

    // flash held inverted: a 2-state zero is an erased byte, so the array
    // powers up blank with no initial loop racing the write process
    bit [7:0] flash_inv [FLASH_BYTES];
    fwg_lk_t lk, next_lk;
    logic we, ee, next_we, next_ee;
    logic resp, next_resp, refused, next_refused, ferr, next_ferr, flag, next_flag;
    logic [7:0] rdata, next_rdata;
    logic rd_pend, next_rd_pend;
    logic [7:0] lock_byte, locked_pages;
    logic [PAGE_W-1:0] tgt_page, exec_page;
    logic any_locked, tgt_locked, exec_locked, out_of_range, protect;
    logic is_flash, allowed, deny_dbg, deny_err, do_write, do_erase;
    logic [15:0] base;

    // lock decode from the lock byte; the full byte is kept, since a page
    // count cut to the page width would wrap for lock bytes below 0x80
    assign lock_byte = ~flash_inv[LOCK_ADDR[13:0]];
    assign locked_pages = ~lock_byte;
    assign any_locked = (lock_byte != ERASED);
    assign tgt_page = lnk.addr[15:PAGE_BITS];
    assign exec_page = lnk.exec_addr[15:PAGE_BITS];

    // same test for the target page and for the page the code runs from
    fwg_page_lock i_tgt_lock (
        .page(tgt_page),
        .locked_pages(locked_pages),
        .any_locked(any_locked),
        .locked(tgt_locked)
    );
    fwg_page_lock i_exec_lock (
        .page(exec_page),
        .locked_pages(locked_pages),
        .any_locked(any_locked),
        .locked(exec_locked)
    );

    // access classification
    // debug is refused outright; firmware from an open page gets an error reset
    always_comb begin
        is_flash = lnk.req && (lnk.op == FWG_OP_CODE_RD || (lnk.op == FWG_OP_XDATA_WR && we));
        out_of_range = lnk.addr > USER_TOP;
        // lock page erase with nothing locked falls out as unprotected
        protect = tgt_locked;
        allowed = is_flash && !out_of_range && (!protect || (!lnk.src_debug && exec_locked));
        deny_dbg = is_flash && lnk.src_debug && (protect || out_of_range);
        deny_err = is_flash && !lnk.src_debug && (out_of_range || (protect && !exec_locked));
        do_write = allowed && lnk.op == FWG_OP_XDATA_WR && lk == FWG_LK_OPEN && !ee;
        do_erase = allowed && lnk.op == FWG_OP_XDATA_WR && lk == FWG_LK_OPEN && ee;
        base = {tgt_page, {PAGE_BITS{1'b0}}};
    end

    // flash array: a write only clears bits, so programming over old data
    // without an erase merges the two; erase returns the page to ff
    always_ff @(posedge ref_clk) begin
        if (do_erase) begin
            for (int i = 0; i < (1 << PAGE_BITS); i++) begin
                flash_inv[14'(base + 16'(i))] <= ~ERASED;
            end
        end else if (do_write) begin
            flash_inv[lnk.addr[13:0]] <= flash_inv[lnk.addr[13:0]] | ~lnk.wdata;
        end
    end

    // data reads and non-flash writes go to ram
    // ram strobes follow req combinationally, so ram sees the link address
    assign ram_we = lnk.req && lnk.op == FWG_OP_XDATA_WR && !we;
    assign ram_re = lnk.req && lnk.op == FWG_OP_XDATA_RD;
    assign ram_addr = lnk.addr;
    assign ram_wdata = lnk.wdata;

    // control, unlock sequence, answer and error flag
    always_comb begin
        next_we = we;
        next_ee = ee;
        next_lk = lk;
        next_resp = lnk.req;
        next_refused = deny_dbg;
        next_ferr = deny_err;
        next_rd_pend = ram_re;
        next_rdata = 8'h00;
        next_flag = flag && !flag_clear;
        if (lnk.req && lnk.op == FWG_OP_CTRL_WR) begin
            next_we = lnk.wdata[CTRL_WE_BIT];
            next_ee = lnk.wdata[CTRL_EE_BIT];
        end
        // unlock sequence; a wrong byte, or a key after the pair, starts over
        if (lnk.req && lnk.op == FWG_OP_KEY_WR) begin
            case (lk)
                FWG_LK_IDLE: begin
                    next_lk = (lnk.wdata == KEY_FIRST) ? FWG_LK_HALF : FWG_LK_IDLE;
                end
                FWG_LK_HALF: begin
                    next_lk = (lnk.wdata == KEY_SECOND) ? FWG_LK_OPEN : FWG_LK_IDLE;
                end
                default: begin
                    next_lk = FWG_LK_IDLE;
                end
            endcase
        end
        // one flash write spends the key pair
        if (lnk.req && lnk.op == FWG_OP_XDATA_WR && we) begin
            next_lk = FWG_LK_IDLE;
        end
        if (allowed && lnk.op == FWG_OP_CODE_RD) begin
            next_rdata = ~flash_inv[lnk.addr[13:0]];
        end
        // error reset returns control state to reset values; the flash is
        // untouched and the flag outlives it so software can find the cause
        if (deny_err) begin
            next_we = 1'b0;
            next_ee = 1'b0;
            next_lk = FWG_LK_IDLE;
            next_flag = 1'b1;
        end
    end

    // control registers; the flash array keeps its contents through reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            we <= 1'b0;
            ee <= 1'b0;
            lk <= FWG_LK_IDLE;
            resp <= 1'b0;
            refused <= 1'b0;
            ferr <= 1'b0;
            rdata <= 8'h00;
            rd_pend <= 1'b0;
            flag <= 1'b0;
        end else begin
            we <= next_we;
            ee <= next_ee;
            lk <= next_lk;
            resp <= next_resp;
            refused <= next_refused;
            ferr <= next_ferr;
            rdata <= next_rdata;
            rd_pend <= next_rd_pend;
            flag <= next_flag;
        end
    end

    // ram answers one cycle after its read strobe
    assign lnk.rdata = rd_pend ? ram_rdata : rdata;
    assign lnk.resp = resp;
    assign lnk.refused = refused;
    assign lnk.ferr_reset = ferr;
    assign flash_error_flag = flag;
    assign store_write_enable = we;
    assign store_erase_enable = ee;
endmodule // fwg_guard

// page lock test, one copy for the target and one for the running code;
// the count compare is one bit wider than a page number so no count wraps
module fwg_page_lock (
    input wire logic [fwg_pkg::PAGE_W-1:0] page,
    input wire logic [7:0] locked_pages,
    input wire logic any_locked,
    output logic locked
);
    import fwg_pkg::*;

    logic [PAGE_W-1:0] lock_page;
    logic in_count;

    // the lock byte page joins the locked set once any page is locked
    assign lock_page = LOCK_ADDR[15:PAGE_BITS];
    assign in_count = {1'b0, page} < locked_pages;
    assign locked = in_count || (any_locked && page == lock_page);
endmodule // fwg_page_lock

// file: design/fwg_ctrl.sv
// access controller: apb registers drive one guard access at a time
`timescale 1ns/1ns
module fwg_ctrl
    import fwg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    fwg_if.ctrl lnk
);
    import fwg_pkg::*;

    logic [3:0] cmd, next_cmd;
    logic [31:0] addr_reg, next_addr_reg;
    logic [7:0] wdata_reg, next_wdata_reg;
    logic busy, next_busy, start, next_start;
    logic [7:0] last_rd, next_last_rd;
    logic last_ref, next_last_ref, last_err, next_last_err;
    logic [2:0] int_stat, next_int_stat, int_en, next_int_en;
    logic wr, rd, mapped;
    logic [2:0] ev;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign mapped = paddr inside {REG_CMD, REG_ADDR, REG_WDATA, REG_STATUS, REG_INT_STAT,
                                  REG_INT_CLR, REG_INT_EN};
    assign ev = {lnk.resp && lnk.ferr_reset, lnk.resp && lnk.refused, lnk.resp};

    // register writes, command launch and event capture
    always_comb begin
        next_cmd = cmd;
        next_addr_reg = addr_reg;
        next_wdata_reg = wdata_reg;
        next_int_en = int_en;
        next_busy = busy;
        next_start = 1'b0;
        next_last_rd = last_rd;
        next_last_ref = last_ref;
        next_last_err = last_err;
        // set wins over a clear in the same cycle
        next_int_stat = int_stat;
        if (wr && paddr == REG_INT_CLR) begin
            next_int_stat = int_stat & ~pwdata[2:0];
        end
        next_int_stat = next_int_stat | ev;
        if (wr) begin
            case (paddr)
                REG_ADDR: next_addr_reg = pwdata;
                REG_WDATA: next_wdata_reg = pwdata[7:0];
                REG_INT_EN: next_int_en = pwdata[2:0];
                REG_CMD: begin
                    // a command while busy is dropped
                    if (!busy) begin
                        next_cmd = pwdata[3:0];
                        next_busy = 1'b1;
                        next_start = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (lnk.resp) begin
            next_busy = 1'b0;
            next_last_rd = lnk.rdata;
            next_last_ref = lnk.refused;
            next_last_err = lnk.ferr_reset;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd <= 4'h0;
            addr_reg <= 32'h0;
            wdata_reg <= 8'h00;
            int_en <= INT_RESET;
            int_stat <= INT_RESET;
            busy <= 1'b0;
            start <= 1'b0;
            last_rd <= 8'h00;
            last_ref <= 1'b0;
            last_err <= 1'b0;
        end else begin
            cmd <= next_cmd;
            addr_reg <= next_addr_reg;
            wdata_reg <= next_wdata_reg;
            int_en <= next_int_en;
            int_stat <= next_int_stat;
            busy <= next_busy;
            start <= next_start;
            last_rd <= next_last_rd;
            last_ref <= next_last_ref;
            last_err <= next_last_err;
        end
    end

    // read mux, zero-wait answer
    always_comb begin
        case (paddr)
            REG_CMD: prdata = {28'h0, cmd};
            REG_ADDR: prdata = addr_reg;
            REG_WDATA: prdata = {24'h0, wdata_reg};
            REG_STATUS: prdata = {21'h0, last_err, last_ref, busy, last_rd};
            REG_INT_STAT: prdata = {29'h0, int_stat};
            REG_INT_EN: prdata = {29'h0, int_en};
            default: prdata = 32'h0;
        endcase
        if (!rd) begin
            prdata = 32'h0;
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq = |(int_stat & int_en);

    // one-cycle request toward the guard
    assign lnk.req = start;
    assign lnk.op = fwg_op_t'(cmd[2:0]);
    assign lnk.src_debug = cmd[CMD_SRC_BIT];
    assign lnk.addr = addr_reg[15:0];
    assign lnk.exec_addr = addr_reg[31:16];
    assign lnk.wdata = wdata_reg;
endmodule // fwg_ctrl

// file: tb/fwg_chk.sv
// link checker for the flash guard
`timescale 1ns/1ns
module fwg_chk
    import fwg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic req,
    input wire fwg_pkg::fwg_op_t op,
    input wire logic src_debug,
    input wire logic [15:0] addr,
    input wire logic [15:0] exec_addr,
    input wire logic [7:0] wdata,
    input wire logic resp,
    input wire logic [7:0] rdata,
    input wire logic refused,
    input wire logic ferr_reset
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_ans; req |=> resp ##1 !resp; endproperty
    property p_dhi; req && src_debug && op == FWG_OP_CODE_RD && addr > USER_TOP |=>
        refused && !ferr_reset; endproperty
    property p_fhi; req && !src_debug && op == FWG_OP_CODE_RD && addr > USER_TOP |=> ferr_reset;
    endproperty
    property p_ram; req && op == FWG_OP_XDATA_RD |=> !refused && !ferr_reset; endproperty
    property p_nod; refused |-> rdata == 8'h00; endproperty
    property p_dbg; req && src_debug |=> !ferr_reset; endproperty
    property p_key; req && op == FWG_OP_KEY_WR |=> !refused && !ferr_reset; endproperty
    property p_evt; refused || ferr_reset |-> resp && $past(req); endproperty
    property p_ctl; req && op == FWG_OP_CTRL_WR |=> !refused && !ferr_reset; endproperty
    a_ans: assert property (p_ans) else $error("answer late or long");
    a_dhi: assert property (p_dhi) else $error("debug high access kept");
    a_fhi: assert property (p_fhi) else $error("high fetch no error");
    a_ram: assert property (p_ram) else $error("data read guarded");
    a_nod: assert property (p_nod) else $error("refused read gave data");
    a_dbg: assert property (p_dbg) else $error("debug caused error reset");
    a_key: assert property (p_key) else $error("key write blocked");
    a_evt: assert property (p_evt) else $error("event without request");
    a_ctl: assert property (p_ctl) else $error("control write blocked");
    c_wr: cover property (req && op == FWG_OP_XDATA_WR);
    c_ref: cover property (refused);
    c_err: cover property (ferr_reset);
endmodule // fwg_chk

// file: tb/tb_flash_write_and_lock_guard.sv
// self-checking bench for the flash write and lock guard
`timescale 1ns/1ns
module tb_flash_write_and_lock_guard;
    import fwg_pkg::*;
    logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, se;
    logic flag_clear, flash_error_flag, store_write_enable, store_erase_enable, ram_we, ram_re;
    logic [7:0] paddr, ram_wdata, ram_rdata;
    logic [15:0] ram_addr;
    logic [23:0] rw;
    logic [31:0] pwdata, prdata, q, st;
    logic [43:0] tbl [7];
    int err_total, checks, cyc;
    fwg_if lnk();
    fwg_ctrl i_fwg_ctrl (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .lnk(lnk));
    fwg_guard i_fwg_guard (.ref_clk(ref_clk), .arst_n(arst_n), .lnk(lnk),
        .flag_clear(flag_clear), .flash_error_flag(flash_error_flag),
        .store_write_enable(store_write_enable), .store_erase_enable(store_erase_enable),
        .ram_we(ram_we), .ram_re(ram_re), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata));
    fwg_chk i_fwg_chk (.ref_clk(ref_clk), .arst_n(arst_n), .req(lnk.req), .op(lnk.op),
        .src_debug(lnk.src_debug), .addr(lnk.addr), .exec_addr(lnk.exec_addr),
        .wdata(lnk.wdata), .resp(lnk.resp), .rdata(lnk.rdata), .refused(lnk.refused),
        .ferr_reset(lnk.ferr_reset));
    // address-derived ram contents, so a wrong address shows up
    assign ram_rdata = ram_addr[7:0] ^ 8'h5a;
    initial begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    // last ram strobe and its address, seen from the guard side; reads log zero data
    always @(posedge ref_clk) if (ram_we || ram_re) rw <= {ram_addr, ram_we ? ram_wdata : 8'h00};
    // hang guard, far above the few hundred cycles used
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task end_sim();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one apb transfer, then an idle cycle so psel is never reassigned in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask
    // launch one guard access and wait for busy to drop
    task go(input fwg_op_t o, input logic d, input logic [15:0] a, ex, input logic [7:0] v);
        int n;
        apb(1, REG_ADDR, {ex, a});
        apb(1, REG_WDATA, {24'h0, v});
        apb(1, REG_CMD, {28'h0, d, o});
        n = 0;
        st = 32'h100;
        while (st[8] !== 1'b0 && n < 50) begin
            apb(0, REG_STATUS, 32'h0);
            st = q;
            n++;
        end
        chk(st[8], 1'b0);
    endtask
    // control byte, both keys, then the data write
    task prog(input logic d, input logic [15:0] a, ex, input logic [7:0] c, v);
        go(FWG_OP_CTRL_WR, d, a, ex, c);
        go(FWG_OP_KEY_WR, d, a, ex, KEY_FIRST);
        go(FWG_OP_KEY_WR, d, a, ex, KEY_SECOND);
        go(FWG_OP_XDATA_WR, d, a, ex, v);
    endtask
    initial begin
        // debug, target, exec page, expected {ferr, refused, busy, data}
        tbl = '{{1'b1, 16'h0000, 16'h0000, 11'h200}, {1'b1, 16'h0400, 16'h0000, 11'h0ff},
            {1'b1, 16'h3dff, 16'h0000, 11'h200}, {1'b0, 16'h3dff, 16'h0000, 11'h0fd},
            {1'b1, 16'h3e00, 16'h0000, 11'h200}, {1'b0, 16'h0000, 16'h0400, 11'h400},
            {1'b0, 16'h3e00, 16'h0000, 11'h400}};
        {psel, penable, pwrite, paddr, pwdata, flag_clear} = '0;
        arst_n = 0;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1;
        @(posedge ref_clk);
        apb(0, REG_INT_STAT, 32'h0);
        chk(q, 32'h0);
        apb(0, 8'h1c, 32'h0);
        chk({se, q[30:0]}, 32'h80000000);
        prog(1, 16'h3c10, 16'h0, 8'h01, 8'h11);
        chk({store_write_enable, store_erase_enable}, 2'b10);
        go(FWG_OP_CODE_RD, 1, 16'h3c10, 16'h0, 8'h0);
        chk(st[10:0], 11'h011);
        go(FWG_OP_XDATA_WR, 1, 16'h3c10, 16'h0, 8'h00);
        go(FWG_OP_CODE_RD, 1, 16'h3c10, 16'h0, 8'h0);
        chk(st[10:0], 11'h011);
        prog(1, 16'h3c00, 16'h0, 8'h03, 8'h00);
        go(FWG_OP_CODE_RD, 1, 16'h3c10, 16'h0, 8'h0);
        chk(st[10:0], 11'h0ff);
        go(FWG_OP_CTRL_WR, 0, 16'h0, 16'h0, 8'h00);
        go(FWG_OP_XDATA_WR, 0, 16'h0020, 16'h0, 8'h77);
        chk(rw, 24'h002077);
        go(FWG_OP_XDATA_RD, 0, 16'h0012, 16'h0, 8'h0);
        chk(st[10:0], 11'h048);
        chk(rw, 24'h001200);
        prog(0, LOCK_ADDR, 16'h0, 8'h01, 8'hfd);
        for (int i = 0; i < 7; i++) begin
            go(FWG_OP_CODE_RD, tbl[i][43], tbl[i][42:27], tbl[i][26:11], 8'h0);
            chk(st[10:0], tbl[i][10:0]);
        end
        chk({flash_error_flag, store_write_enable}, 2'b10);
        chk(irq, 1'b0);
        apb(1, REG_INT_EN, 32'h4);
        chk(irq, 1'b1);
        apb(0, REG_INT_STAT, 32'h0);
        chk(q, 32'h7);
        apb(1, REG_INT_CLR, 32'h7);
        chk(irq, 1'b0);
        flag_clear <= 1;
        @(posedge ref_clk);
        flag_clear <= 0;
        @(posedge ref_clk);
        chk(flash_error_flag, 1'b0);
        prog(1, 16'h0000, 16'h0, 8'h01, 8'h00);
        chk(st[10:0], 11'h200);
        go(FWG_OP_CODE_RD, 0, 16'h0000, 16'h0, 8'h0);
        chk(st[10:0], 11'h0ff);
        end_sim();
    end
endmodule // tb_flash_write_and_lock_guard
